// file: src/pck_regs.svh
// constants for the phase coherent two-tone keyer
// assumes a single system clock; included by bare name
`ifndef PCK_REGS_SVH
`define PCK_REGS_SVH

// system clock rate in hertz
`define PCK_CLK_HZ          125000000
// tone offsets above the nominal carrier, in hertz
`define PCK_LOW_OFS_HZ      2400
`define PCK_HIGH_OFS_HZ     4800
// reference runs at this multiple of the receive frequency
`define PCK_LO_DIVIDE       4
// expected bit-phase clock period in system cycles
`define PCK_BIT_PERIOD_CYC  (`PCK_CLK_HZ / (`PCK_HIGH_OFS_HZ - `PCK_LOW_OFS_HZ))
// default accepted deviation of that period, in cycles
`define PCK_PERIOD_TOL_CYC  (`PCK_BIT_PERIOD_CYC / 8)
// width of the period counter
`define PCK_PERIOD_W        17
// depth of the keying bit queue, in words
`define PCK_FIFO_DEPTH      8
// width of one queued keying word
`define PCK_FIFO_WIDTH      1
// reset value of the tone selection: low tone
`define PCK_TONE_RESET      1'b0

`endif

// file: src/pck_pkg.sv
// types shared by the keyer files
// assumes the constants header is included by the users
package pck_pkg;

    // pins that arrive from outside the clock domain
    typedef struct packed {
        logic lo_ref;
        logic low_tone;
        logic high_tone;
        logic key_enable;
        logic listen_enable;
        logic single_antenna;
    } pck_pins_s;

    // quadrature local oscillator pair
    typedef struct packed {
        logic in_phase;
        logic quadrature;
    } pck_lo_s;

    // power amplifier keying states
    typedef enum logic [1:0] {
        PCK_IDLE,
        PCK_ARMED,
        PCK_KEYING
    } pck_key_state_e;

endpackage

// file: src/pck_fifo.sv
// small synchronous fifo with valid/ready on both sides
// assumes one clock; depth a power of two so pointers wrap freely
`timescale 1ns/100ps
`default_nettype none
module pck_fifo #(
    parameter int WIDTH = 1,
    parameter int DEPTH = 8
) (
    input  wire logic             i_sys_clk,
    input  wire logic             i_reset_n,
    input  wire logic             i_in_valid,
    output logic                  o_in_ready,
    input  wire logic [WIDTH-1:0] i_in_data,
    output logic                  o_out_valid,
    input  wire logic             i_out_ready,
    output logic      [WIDTH-1:0] o_out_data
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_q;
    logic [AW-1:0]    rd_q;
    logic [CW-1:0]    cnt_q;
    logic             push;
    logic             pop;

    assign o_in_ready  = (cnt_q != CW'(DEPTH));
    assign o_out_valid = (cnt_q != '0);
    assign o_out_data  = mem_q[rd_q];
    assign push        = i_in_valid & o_in_ready;
    assign pop         = o_out_valid & i_out_ready;

    // storage carries no reset; only the count defines emptiness
    always_ff @(posedge i_sys_clk) begin
        if (push) begin
            mem_q[wr_q] <= i_in_data;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            if (push) begin
                wr_q <= wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= rd_q + 1'b1;
            end
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            cnt_q <= '0;
        end else begin
            unique case ({push, pop})
                2'b10:   cnt_q <= cnt_q + 1'b1;
                2'b01:   cnt_q <= cnt_q - 1'b1;
                default: cnt_q <= cnt_q;
            endcase
        end
    end
endmodule // pck_fifo
`default_nettype wire

// file: src/pck_keyer.sv
// phase coherent two-tone keyer with quadrature lo divider
// assumes tone and reference pins far slower than the system clock;
// the host pushes keying bits on the same clock as this block
//
// How it works
// - the reference clock is divided by four into two square waves 90 degrees apart, the in-phase and quadrature oscillators.
// - the tones sit 2400 Hz and 4800 Hz above reference/4; only their spacing is checked, through the bit-phase period.
// - while keying, exactly one of the two tone clocks reaches the amplifier drive, picked by the tone-select bit; otherwise the drive is low.
// - the selected tone changes only when the two tone clocks are in phase.
// - a flip-flop samples the low tone on each rising edge of the high tone, toggling at 0 and 180 degrees.
// - the flip-flop output is the bit-phase clock, at the tone difference of nominally 2400 Hz.
// - keying at 2400 bit/s puts one or two whole baseband tone cycles in each bit.
// - audio is muted whenever the listen enable is low.
// - with a single antenna the listen enable drives the amplifier-to-receiver switch.
`timescale 1ns/100ps
`default_nettype none
`include "pck_regs.svh"
module pck_keyer
    import pck_pkg::*;
#(
    parameter logic [`PCK_PERIOD_W-1:0] BIT_PERIOD_CYC =
        `PCK_PERIOD_W'(`PCK_BIT_PERIOD_CYC),
    parameter logic [`PCK_PERIOD_W-1:0] PERIOD_TOL_CYC =
        `PCK_PERIOD_W'(`PCK_PERIOD_TOL_CYC)
) (
    input  wire logic i_sys_clk,
    input  wire logic i_reset_n,
    input  wire logic i_lo_reference_clock,
    input  wire logic i_low_tone_clock,
    input  wire logic i_high_tone_clock,
    input  wire logic i_key_enable,
    input  wire logic i_listen_enable,
    input  wire logic i_single_antenna,
    input  wire logic i_tone_select_valid,
    input  wire logic i_tone_select_data,
    output logic      o_tone_select_ready,
    output logic      o_in_phase_oscillator,
    output logic      o_quadrature_oscillator,
    output logic      o_phase_detector_output,
    output logic      o_bit_strobe,
    output logic      o_tone_select,
    output logic      o_pa_drive,
    output logic      o_pa_keying,
    output logic      o_audio_mute,
    output logic      o_antenna_route,
    output logic      o_tone_offset_ok
);
    localparam logic [`PCK_PERIOD_W-1:0] PER_LO =
        BIT_PERIOD_CYC - PERIOD_TOL_CYC;
    localparam logic [`PCK_PERIOD_W-1:0] PER_HI =
        BIT_PERIOD_CYC + PERIOD_TOL_CYC;
    localparam logic [`PCK_PERIOD_W-1:0] PER_MAX = '1;

    pck_pins_s      pins;
    pck_pins_s      meta_q;
    pck_pins_s      s_q;
    pck_pins_s      prev_q;
    pck_lo_s        lo_q;
    pck_key_state_e state_q;
    pck_key_state_e state_d;
    logic           lo_rise;
    logic           hi_rise;
    logic           pd_q;
    logic           pd_prev_q;
    logic           bit_edge;
    logic           tone_q;
    logic           pa_q;
    logic           strobe_q;
    logic           mute_q;
    logic           route_q;
    logic           ok_q;
    logic           q_valid;
    logic           q_data;
    logic [1:0]     warm_q;
    logic [`PCK_PERIOD_W-1:0] per_q;

    // shared by the drive path and its check
    function automatic logic pick_tone(input logic sel,
                                       input logic low,
                                       input logic high);
        return sel ? high : low;
    endfunction

    assign pins = '{lo_ref:         i_lo_reference_clock,
                    low_tone:       i_low_tone_clock,
                    high_tone:      i_high_tone_clock,
                    key_enable:     i_key_enable,
                    listen_enable:  i_listen_enable,
                    single_antenna: i_single_antenna};

    // two-stage synchroniser; prev_q only feeds edge detection
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            meta_q <= '0;
            s_q    <= '0;
            prev_q <= '0;
        end else begin
            meta_q <= pins;
            s_q    <= meta_q;
            prev_q <= s_q;
        end
    end

    // edges count only once prev_q holds a real sample, else an
    // idle-high pin looks like a rise and pops a bit right after reset
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            warm_q <= '0;
        end else if (warm_q != 2'h3) begin
            warm_q <= warm_q + 1'b1;
        end
    end

    assign lo_rise = (warm_q == 2'h3) & s_q.lo_ref & ~prev_q.lo_ref;
    assign hi_rise = (warm_q == 2'h3) & s_q.high_tone
                   & ~prev_q.high_tone;

    // johnson pair: 00,10,11,01 gives two phases a quarter apart;
    // only valid while the reference is well below half the clock
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            lo_q <= '0;
        end else if (lo_rise) begin
            lo_q <= '{in_phase:   ~lo_q.quadrature,
                      quadrature: lo_q.in_phase};
        end
    end

    assign o_in_phase_oscillator   = lo_q.in_phase;
    assign o_quadrature_oscillator = lo_q.quadrature;

    // phase detector: low tone sampled by the high tone
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            pd_q      <= 1'b0;
            pd_prev_q <= 1'b0;
        end else begin
            if (hi_rise) begin
                pd_q <= s_q.low_tone;
            end
            pd_prev_q <= pd_q;
        end
    end

    // rising bit-phase edge marks the in-phase instant
    assign bit_edge                = pd_q & ~pd_prev_q;
    assign o_phase_detector_output = pd_q;

    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            strobe_q <= 1'b0;
        end else begin
            strobe_q <= bit_edge;
        end
    end

    assign o_bit_strobe = strobe_q;

    // queue lets the host run ahead instead of racing each edge
    pck_fifo #(
        .WIDTH (`PCK_FIFO_WIDTH),
        .DEPTH (`PCK_FIFO_DEPTH)
    ) u_bit_queue (
        .i_sys_clk   (i_sys_clk),
        .i_reset_n   (i_reset_n),
        .i_in_valid  (i_tone_select_valid),
        .o_in_ready  (o_tone_select_ready),
        .i_in_data   (i_tone_select_data),
        .o_out_valid (q_valid),
        .i_out_ready (bit_edge),
        .o_out_data  (q_data)
    );

    // an empty queue at the edge holds the previous tone
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            tone_q <= `PCK_TONE_RESET;
        end else if (bit_edge && q_valid) begin
            tone_q <= q_data;
        end
    end

    assign o_tone_select = tone_q;

    // keying opens only on an in-phase edge so the first bit is whole
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            PCK_IDLE: begin
                if (s_q.key_enable) begin
                    state_d = PCK_ARMED;
                end
            end
            PCK_ARMED: begin
                if (!s_q.key_enable) begin
                    state_d = PCK_IDLE;
                end else if (bit_edge) begin
                    state_d = PCK_KEYING;
                end
            end
            PCK_KEYING: begin
                if (!s_q.key_enable) begin
                    state_d = PCK_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state_q <= PCK_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    assign o_pa_keying = (state_q == PCK_KEYING);

    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            pa_q <= 1'b0;
        end else if (state_q == PCK_KEYING) begin
            pa_q <= pick_tone(tone_q, s_q.low_tone, s_q.high_tone);
        end else begin
            pa_q <= 1'b0;
        end
    end

    assign o_pa_drive = pa_q;

    // listen enable gates audio and the shared antenna path
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            mute_q  <= 1'b1;
            route_q <= 1'b0;
        end else begin
            mute_q  <= ~s_q.listen_enable;
            route_q <= s_q.single_antenna & s_q.listen_enable;
        end
    end

    assign o_audio_mute    = mute_q;
    assign o_antenna_route = route_q;

    // tone spacing shows as the bit-phase period; a stalled tone
    // saturates the counter and drops the flag
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            per_q <= '0;
            ok_q  <= 1'b0;
        end else if (bit_edge) begin
            per_q <= `PCK_PERIOD_W'(1);
            ok_q  <= (per_q >= PER_LO) && (per_q <= PER_HI);
        end else if (per_q != PER_MAX) begin
            per_q <= per_q + 1'b1;
        end else begin
            ok_q  <= 1'b0;
        end
    end

    assign o_tone_offset_ok = ok_q;

    property p_lo_step;
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        !($changed(lo_q.in_phase) && $changed(lo_q.quadrature));
    endproperty
    a_lo_step: assert property (p_lo_step)
        else $error("lo phases moved together");

    property p_lo_divide;
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        lo_rise |=> (lo_q.quadrature == $past(lo_q.in_phase))
                 && (lo_q.in_phase != $past(lo_q.quadrature));
    endproperty
    a_lo_divide: assert property (p_lo_divide)
        else $error("lo divider did not advance");

    property p_one_tone;
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        (state_q == PCK_KEYING) |=> o_pa_drive ==
            pick_tone($past(tone_q), $past(s_q.low_tone),
                      $past(s_q.high_tone));
    endproperty
    a_one_tone: assert property (p_one_tone)
        else $error("amplifier drive is not the selected tone");

    property p_tone_aligned;
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        $changed(tone_q) |-> $past(bit_edge) && $past(q_valid);
    endproperty
    a_tone_aligned: assert property (p_tone_aligned)
        else $error("tone changed away from an in-phase edge");

    property p_detector;
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        hi_rise |=> (pd_q == $past(s_q.low_tone))
            ##1 (o_bit_strobe == ($past(pd_q) && !$past(pd_q, 2)));
    endproperty
    a_detector: assert property (p_detector)
        else $error("phase detector missed its sample");

    property p_period;
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        bit_edge |=> o_tone_offset_ok ==
            (($past(per_q) >= PER_LO) && ($past(per_q) <= PER_HI));
    endproperty
    a_period: assert property (p_period)
        else $error("offset flag disagrees with measured period");

    property p_key_start;
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        $rose(o_pa_keying) |-> $past(bit_edge) && $past(s_q.key_enable);
    endproperty
    a_key_start: assert property (p_key_start)
        else $error("keying began off an in-phase edge");

    property p_mute;
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        !s_q.listen_enable |=> o_audio_mute && !o_antenna_route;
    endproperty
    a_mute: assert property (p_mute)
        else $error("audio or antenna path open while not listening");

    property p_route;
        @(posedge i_sys_clk) disable iff (!i_reset_n)
        (s_q.listen_enable && s_q.single_antenna) |=> o_antenna_route
            && !o_audio_mute;
    endproperty
    a_route: assert property (p_route)
        else $error("single antenna switch not following listen");
endmodule // pck_keyer
`default_nettype wire

// file: bench/pck_tone_src.sv
// reference and tone clock source standing in for the clock chip
// assumes the bench clock; pins move on the falling edge only
`timescale 1ns/100ps
`default_nettype none
module pck_tone_src #(
    parameter int REF_HALF  = 4,
    parameter int LOW_HALF  = 5,
    parameter int HIGH_HALF = 4
) (
    input  wire logic i_sys_clk,
    input  wire logic i_run,
    output logic      o_ref,
    output logic      o_low,
    output logic      o_high
);
    int ref_cnt  = 0;
    int low_cnt  = 0;
    int high_cnt = 0;

    // frozen together while stopped, so the beat phase survives a pause
    always @(negedge i_sys_clk) begin
        if (i_run) begin
            ref_cnt <= (ref_cnt + 1) % (2 * REF_HALF);
            low_cnt <= (low_cnt + 1) % (2 * LOW_HALF);
            high_cnt <= (high_cnt + 1) % (2 * HIGH_HALF);
        end
    end

    assign o_ref  = (ref_cnt < REF_HALF);
    assign o_low  = (low_cnt < LOW_HALF);
    assign o_high = (high_cnt < HIGH_HALF);
endmodule // pck_tone_src
`default_nettype wire

// file: bench/phase_coherent_fsk_keyer_bench.sv
// self-checking bench for the two-tone keyer
// assumes tone periods 8 and 10 cycles, so one bit every 40 cycles
`timescale 1ns/100ps
`default_nettype none
`include "pck_regs.svh"
module phase_coherent_fsk_keyer_bench;
    localparam int PER = 40;
    localparam int TOL = 8;
    logic clk = 1'b0, rst_n = 1'b0, run = 1'b0, key = 1'b0;
    logic lis = 1'b0, sgl = 1'b0, vld = 1'b0, dat = 1'b0;
    logic ref_c, low_c, high_c, rdy, i_osc, q_osc, pd, stb, tsel;
    logic pad, pak, mute, route, ok;
    logic q_m[$];
    logic tone_m = 1'b0, pak_p = 1'b0, pad_p = 1'b0;
    logic [1:0] lo_p = 2'h0;
    logic [7:0] rnd = 8'h14;
    int err_count = 0, compares = 0, cyc = 0, last_stb = -1;
    int lo_t = 0, gap = 0, pad_rise = 0, n = 0, e = 0;

    pck_tone_src pck_tone_src_i (.i_sys_clk(clk), .i_run(run),
        .o_ref(ref_c), .o_low(low_c), .o_high(high_c));

    pck_keyer #(.BIT_PERIOD_CYC(17'h28), .PERIOD_TOL_CYC(17'h8))
    pck_keyer_i (
        .i_sys_clk(clk), .i_reset_n(rst_n), .i_lo_reference_clock(ref_c),
        .i_low_tone_clock(low_c), .i_high_tone_clock(high_c),
        .i_key_enable(key), .i_listen_enable(lis),
        .i_single_antenna(sgl), .i_tone_select_valid(vld),
        .i_tone_select_data(dat), .o_tone_select_ready(rdy),
        .o_in_phase_oscillator(i_osc), .o_quadrature_oscillator(q_osc),
        .o_phase_detector_output(pd), .o_bit_strobe(stb),
        .o_tone_select(tsel), .o_pa_drive(pad), .o_pa_keying(pak),
        .o_audio_mute(mute), .o_antenna_route(route),
        .o_tone_offset_ok(ok));

    initial begin
        forever #4 clk = ~clk;
    end

    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    task automatic check(input logic seen, input logic exp,
                         input string msg);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %0t %s", $time, msg);
        end
    endtask

    task automatic summarize();
        if (err_count == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // model: pop at each strobe first, since the design popped a cycle ago
    always @(posedge clk) begin
        cyc++;
        if (rst_n && stb === 1'b1) begin
            if (q_m.size() > 0) begin
                tone_m = q_m.pop_front();
            end
            check(tsel, tone_m, "tone select");
            check(pd, 1'b1, "bit clock level");
            if (last_stb >= 0) begin
                gap = cyc - last_stb;
                check(ok, gap >= PER - TOL && gap <= PER + TOL, "ok");
                if (gap < 2 * PER) begin
                    check(gap == PER, 1'b1, "bit period");
                end
            end
            last_stb = cyc;
        end
        if (rst_n && vld === 1'b1 && rdy === 1'b1) begin
            q_m.push_back(dat);
        end
        if (rst_n && {i_osc, q_osc} !== lo_p) begin
            if (lo_t > 0 && cyc - lo_t < 50) begin
                check(cyc - lo_t == 8, 1'b1, "lo step");
                check($countones({i_osc, q_osc} ^ lo_p) == 1, 1'b1,
                      "lo order");
            end
            lo_t = cyc;
            lo_p = {i_osc, q_osc};
        end
        if (pak === 1'b1 && pak_p === 1'b0) begin
            check(stb, 1'b1, "keying start");
        end
        if (pak === 1'b0 && pak_p === 1'b0) begin
            check(pad, 1'b0, "drive idle");
        end
        if (pad === 1'b1 && pad_p === 1'b0) begin
            pad_rise++;
        end
        pak_p = pak;
        pad_p = pad;
        if (cyc > 20000) begin
            err_count++;
            summarize();
        end
    end

    initial begin
        repeat (4) @(negedge clk);
        rst_n = 1'b1;
        check(tsel, 1'b0, "reset tone");
        check(pak, 1'b0, "reset keying");
        check(rdy, 1'b1, "reset ready");
        for (int k = 0; k < 4; k++) begin
            lis = k[0];
            sgl = k[1];
            repeat (4) @(negedge clk);
            check(mute, !lis, "mute");
            check(route, lis & sgl, "route");
        end
        // first round overfills to see the ninth push refused
        for (int r = 0; r < 4; r++) begin
            run = 1'b0;
            repeat (20) @(negedge clk);
            n = (r == 0) ? 9 : 1 + rnd[2:0];
            for (int k = 0; k < n; k++) begin
                check(rdy, q_m.size() < 8, "ready");
                rnd = lfsr(rnd);
                vld = 1'b1;
                dat = rnd[0];
                @(negedge clk);
            end
            vld = 1'b0;
            repeat (100) @(negedge clk);
            key = r[0];
            run = 1'b1;
            for (int w = 0; w < 600 && q_m.size() > 0; w++) begin
                @(negedge clk);
            end
            repeat (2 * PER) @(negedge clk);
            pad_rise = 0;
            e = key ? (tone_m ? 10 : 8) : 0;
            repeat (80) @(negedge clk);
            check(pad_rise >= e - 1 && pad_rise <= e + 1, 1'b1,
                  "drive rate");
        end
        key = 1'b0;
        repeat (5) @(negedge clk);
        check(pak, 1'b0, "keying off");
        summarize();
    end
endmodule // phase_coherent_fsk_keyer_bench
`default_nettype wire
